// ---- hw/serial_ctrl_command_bit_decoder.sv ----
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
// How it works
// - All 32 select addresses decode to a command, flag or data bit.
// - Any bit 31 write resets; all flags clear except control-load and tx-empty set.
// - Bit 30 one clears transmitter and its interrupts only.
// - Bit 30 zero clears receiver and its interrupts only.
// - Bit 29 one clears transmit CRC, any mode.
// - Bit 29 zero clears receive CRC, any mode.
// - Mode 1, bit 28 one inhibits zero insertion.
// - Mode 1, bit 28 zero inserts zero after five ones.
// - Mode 3, bit 28 sets or clears sync character discard.
// - Gated discard (FLAGS bit 7) inactive while transparent bit 23 is set; the rx_sync_char_discard output is not gated.
// - Modes 0-3, bit 27 sets or clears sync B load enable.
// - Mode 1, bit 26 one enables holding register read.
// - Mode 1, bit 26 zero clears read enable and holding flags.
// - Modes 2-3, bit 26 sets or clears sync A load enable.
// - Bits 11-0 are data for the register being loaded.
// - Bit 12 is the receive CRC load enable.
// - Bit 14 is the control register load enable.
// - Bit 13 is the interval timer load enable.
// - Chip select inactive: read line released, strobe ignored.
// - Bit 25 sets tx buffer/CRC load enable; zero also clears tx-empty.
module serial_ctrl_command_bit_decoder (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // Command bus pins
  input  wire logic [4:0]                  bit_select_lines,
  input  wire logic                        chip_select_n,
  input  wire logic                        cmd_bus_write_data,
  input  wire logic                        cmd_bus_write_strobe,
  input  wire logic                        rd_bit_in,
  output logic                             cmd_bus_read_data,
  output logic                             cmd_bus_read_oe,
  // Mode input and decoded outputs
  input  wire logic [2:0]                  op_mode,
  output cmd_decode_pkg::cmd_pulse_s       cmd_pulse,
  output logic [11:0]                      data_field,
  output logic [31:0]                      flag_bits,
  output logic                             tx_bit_stuff_inhibit,
  output logic                             rx_sync_char_discard,
  output logic                             sync_b_load_enable,
  output logic                             sync_a_load_enable,
  output logic                             hold_reg_read_enable,
  output logic                             txbuf_and_crc_load_enable,
  output logic                             tx_buffer_empty_flag,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [7:0]                  haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic [31:0]                      hrdata,
  output logic                             hreadyout,
  output logic                             hresp
);
  import cmd_decode_pkg::*;

  // Pin synchronisers, two stages before any use
  logic [4:0] sel_s1_r, sel_s2_r;
  logic [2:0] ctl_s1_r, ctl_s2_r, ctl_s3_r;
  logic       rd_s1_r, rd_s2_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_s1_r <= 5'h00;
      sel_s2_r <= 5'h00;
      ctl_s1_r <= 3'h1;
      ctl_s2_r <= 3'h1;
      ctl_s3_r <= 3'h1;
      rd_s1_r  <= 1'b0;
      rd_s2_r  <= 1'b0;
    end else begin
      sel_s1_r <= bit_select_lines;
      sel_s2_r <= sel_s1_r;
      ctl_s1_r <= {cmd_bus_write_strobe, cmd_bus_write_data, chip_select_n};
      ctl_s2_r <= ctl_s1_r;
      ctl_s3_r <= ctl_s2_r;
      rd_s1_r  <= rd_bit_in;
      rd_s2_r  <= rd_s1_r;
    end
  end

  // Strobe rising edge with chip select low; cs high blocks the strobe
  logic       pin_write;
  cmd_write_s pin_cmd;
  assign pin_write   = ctl_s2_r[2] && !ctl_s3_r[2] && !ctl_s2_r[0];
  assign pin_cmd.sel  = sel_s2_r;
  assign pin_cmd.data = ctl_s2_r[1];

  // Read line driven only while selected
  assign cmd_bus_read_oe   = !ctl_s2_r[0];
  assign cmd_bus_read_data = rd_s2_r && !ctl_s2_r[0];

  // AHB-Lite: zero wait state, always OKAY
  logic       ah_wr_pend_r;
  logic [7:0] ah_addr_r;
  logic       ah_take;
  assign ah_take   = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ah_wr_pend_r <= 1'b0;
      ah_addr_r    <= 8'h00;
    end else begin
      ah_wr_pend_r <= ah_take && hwrite;
      if (ah_take) begin
        ah_addr_r <= haddr;
      end
    end
  end

  // Software may also issue a command write through the CMD register
  logic       sw_write;
  logic       mode_wr;
  assign sw_write = ah_wr_pend_r && (ah_addr_r == OFS_CMD);
  assign mode_wr  = ah_wr_pend_r && (ah_addr_r == OFS_MODE);

  // Mode register; software value overrides the pin mode when valid
  logic [2:0] mode_r;
  logic       mode_sw_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r    <= 3'h0;
      mode_sw_r <= 1'b0;
    end else if (mode_wr) begin
      mode_r    <= hwdata[2:0];
      mode_sw_r <= hwdata[8];
    end
  end

  op_mode_e mode;
  assign mode = op_mode_e'(mode_sw_r ? mode_r : op_mode);

  // Pin write wins over a simultaneous software write
  logic       wr;
  cmd_write_s cmd;
  assign wr       = pin_write || sw_write;
  assign cmd.sel  = pin_write ? pin_cmd.sel : hwdata[12:8];
  assign cmd.data = pin_write ? pin_cmd.data : hwdata[0];

  function automatic logic hit(input logic w, input logic [4:0] s, input logic [4:0] a);
    hit = w && (s == a);
  endfunction : hit

  // Every address but bit 31 stores its bit; a bit 31 write clears all but ctrl load
  logic [31:0] bits_r;
  logic        is_reset;
  assign is_reset = hit(wr, cmd.sel, BIT_RESET);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bits_r <= FLAGS_RESET;
    end else if (is_reset) begin
      bits_r <= FLAGS_RESET;
    end else if (wr) begin
      bits_r[cmd.sel] <= cmd.data;
    end
  end

  // Mode-dependent command flags; other modes leave them untouched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_bit_stuff_inhibit <= 1'b0;
      rx_sync_char_discard <= 1'b0;
      sync_b_load_enable   <= 1'b0;
      sync_a_load_enable   <= 1'b0;
      hold_reg_read_enable <= 1'b0;
    end else if (is_reset) begin
      tx_bit_stuff_inhibit <= 1'b0;
      rx_sync_char_discard <= 1'b0;
      sync_b_load_enable   <= 1'b0;
      sync_a_load_enable   <= 1'b0;
      hold_reg_read_enable <= 1'b0;
    end else begin
      if (hit(wr, cmd.sel, BIT_ZINH_SYNDL)) begin
        if (mode == MODE_1) tx_bit_stuff_inhibit <= cmd.data;
        if (mode == MODE_3) rx_sync_char_discard <= cmd.data;
      end
      if (hit(wr, cmd.sel, BIT_LD_SYNB) && !mode[2]) begin
        sync_b_load_enable <= cmd.data;
      end
      if (hit(wr, cmd.sel, BIT_RHR_SYNA)) begin
        if (mode == MODE_1) hold_reg_read_enable <= cmd.data;
        if (mode == MODE_2 || mode == MODE_3) sync_a_load_enable <= cmd.data;
      end
    end
  end

  // Discard is gated by transparent fill
  logic discard_gated;
  assign discard_gated = rx_sync_char_discard && !bits_r[BIT_XPARENT];

  // Tx buffer load enable and empty flag; reset sets the flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txbuf_and_crc_load_enable <= 1'b0;
      tx_buffer_empty_flag      <= 1'b1;
    end else if (is_reset) begin
      txbuf_and_crc_load_enable <= 1'b0;
      tx_buffer_empty_flag      <= 1'b1;
    end else if (hit(wr, cmd.sel, BIT_LD_TXBC)) begin
      txbuf_and_crc_load_enable <= cmd.data;
      if (!cmd.data) tx_buffer_empty_flag <= 1'b0;
    end else if (hit(wr, cmd.sel, BIT_CLR_TXRX) && cmd.data) begin
      tx_buffer_empty_flag <= 1'b1;
    end
  end

  // One-cycle command strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_pulse <= '0;
    end else begin
      cmd_pulse.dev_reset         <= is_reset;
      cmd_pulse.transmitter_clear <= hit(wr, cmd.sel, BIT_CLR_TXRX) && cmd.data;
      cmd_pulse.receiver_clear    <= hit(wr, cmd.sel, BIT_CLR_TXRX) && !cmd.data;
      cmd_pulse.tx_crc_clear      <= hit(wr, cmd.sel, BIT_CLR_CRC) && cmd.data;
      cmd_pulse.rx_crc_clear      <= hit(wr, cmd.sel, BIT_CLR_CRC) && !cmd.data;
      cmd_pulse.hold_flags_clear  <= hit(wr, cmd.sel, BIT_RHR_SYNA) && !cmd.data
                                     && mode == MODE_1;
      cmd_pulse.tx_empty_clear    <= hit(wr, cmd.sel, BIT_LD_TXBC) && !cmd.data;
    end
  end

  // Data field and load enables, registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_field <= 12'h000;
      flag_bits  <= FLAGS_RESET;
    end else begin
      data_field <= bits_r[DATA_BITS-1:0];
      flag_bits  <= {bits_r[31:15], bits_r[BIT_LD_CTRL], bits_r[BIT_LD_INTV],
                     bits_r[BIT_LD_RXCRC], bits_r[11:0]};
    end
  end

  // Register read mux; unmapped addresses read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ah_take && !hwrite) begin
      unique case (haddr)
        OFS_CMD:    hrdata <= bits_r;
        OFS_FLAGS:  hrdata <= {24'h000000, discard_gated, tx_buffer_empty_flag,
                               txbuf_and_crc_load_enable, hold_reg_read_enable,
                               sync_a_load_enable, sync_b_load_enable,
                               rx_sync_char_discard, tx_bit_stuff_inhibit};
        OFS_MODE:   hrdata <= {23'h000000, mode_sw_r, 5'h00, mode};
        OFS_PULSES: hrdata <= {25'h0000000, cmd_pulse};
        default:    hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Assertions
  a_reset_sets_ctrl: assert property (@(posedge hclk) disable iff (!hresetn)
    is_reset |=> bits_r[BIT_LD_CTRL] && tx_buffer_empty_flag && !sync_b_load_enable)
    else $error("reset did not set ctrl load and tx empty");
  a_clr_tx_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_CLR_TXRX) && cmd.data |=> cmd_pulse.transmitter_clear
      && !cmd_pulse.receiver_clear)
    else $error("transmitter clear missing");
  a_clr_rx_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_CLR_TXRX) && !cmd.data |=> cmd_pulse.receiver_clear
      && !cmd_pulse.transmitter_clear)
    else $error("receiver clear missing");
  a_crc_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_CLR_CRC) |=> cmd_pulse.tx_crc_clear != cmd_pulse.rx_crc_clear)
    else $error("crc clear wrong");
  a_stuff_mode1: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_ZINH_SYNDL) && mode == MODE_1 |=>
      tx_bit_stuff_inhibit == $past(cmd.data))
    else $error("stuff inhibit not stored");
  a_discard_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    bits_r[BIT_XPARENT] |-> !discard_gated)
    else $error("discard active in transparent");
  a_cs_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
    ctl_s2_r[0] |-> !pin_write && !cmd_bus_read_oe)
    else $error("write taken while deselected");
  a_bit_store: assert property (@(posedge hclk) disable iff (!hresetn)
    wr && !is_reset |=> bits_r[$past(cmd.sel)] == $past(cmd.data))
    else $error("addressed bit not stored");
  a_txbc_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_LD_TXBC) && !cmd.data |=> !tx_buffer_empty_flag
      && !txbuf_and_crc_load_enable)
    else $error("tx empty not cleared");
  // Deselected pins may not touch the stored bits; only software can then
  a_cs_no_store: assert property (@(posedge hclk) disable iff (!hresetn)
    ctl_s2_r[0] && !sw_write |=> bits_r == $past(bits_r))
    else $error("stored bits changed while deselected");
  a_crc_polarity: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_CLR_CRC) |=> cmd_pulse.tx_crc_clear == $past(cmd.data))
    else $error("crc clear polarity wrong");
  // Mode-gated bits; in unused modes a write must leave the level alone
  a_discard_mode3: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_ZINH_SYNDL) && mode == MODE_3 |=>
      rx_sync_char_discard == $past(cmd.data) && $stable(tx_bit_stuff_inhibit))
    else $error("sync discard not stored");
  a_bit28_unused: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_ZINH_SYNDL) && mode != MODE_1 && mode != MODE_3 |=>
      $stable(tx_bit_stuff_inhibit) && $stable(rx_sync_char_discard))
    else $error("bit 28 acted in an unused mode");
  a_sync_b_load: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_LD_SYNB) && !mode[2] |=> sync_b_load_enable == $past(cmd.data))
    else $error("sync b load enable not stored");
  a_sync_b_unused: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_LD_SYNB) && mode[2] |=> $stable(sync_b_load_enable))
    else $error("bit 27 acted in an unused mode");
  a_hold_read: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_RHR_SYNA) && mode == MODE_1 |=>
      hold_reg_read_enable == $past(cmd.data) && $stable(sync_a_load_enable))
    else $error("hold read enable not stored");
  a_hold_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_RHR_SYNA) && !cmd.data && mode == MODE_1 |=>
      cmd_pulse.hold_flags_clear)
    else $error("holding flags clear missing");
  a_sync_a_load: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_RHR_SYNA) && (mode == MODE_2 || mode == MODE_3) |=>
      sync_a_load_enable == $past(cmd.data) && $stable(hold_reg_read_enable))
    else $error("sync a load enable not stored");
  // Registered copies follow the stored bits by one cycle
  a_data_copy: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> data_field == $past(bits_r[DATA_BITS-1:0]))
    else $error("data field does not follow stored bits");
  a_load_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> flag_bits[14:12] == $past(bits_r[14:12]))
    else $error("load enable flags do not follow stored bits");
  // Transmit buffer enable and empty flag
  a_txbc_one: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_LD_TXBC) && cmd.data |=> txbuf_and_crc_load_enable
      && $stable(tx_buffer_empty_flag))
    else $error("tx buffer load enable not set");
  a_tx_clear_empty: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_CLR_TXRX) && cmd.data |=> tx_buffer_empty_flag)
    else $error("transmitter clear left tx empty low");
  a_rx_clear_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr, cmd.sel, BIT_CLR_TXRX) && !cmd.data |=> $stable(tx_buffer_empty_flag))
    else $error("receiver clear disturbed tx empty");
  a_reset_levels: assert property (@(posedge hclk) disable iff (!hresetn)
    is_reset |=> cmd_pulse.dev_reset && !tx_bit_stuff_inhibit && !rx_sync_char_discard
      && !sync_a_load_enable && !hold_reg_read_enable && !txbuf_and_crc_load_enable)
    else $error("device reset left a level set");

endmodule : serial_ctrl_command_bit_decoder

// ---- pkg/cmd_decode_pkg.sv ----
package cmd_decode_pkg;

  // Bit addresses in the output command space
  localparam logic [4:0] BIT_RESET      = 5'h1f;
  localparam logic [4:0] BIT_CLR_TXRX   = 5'h1e;
  localparam logic [4:0] BIT_CLR_CRC    = 5'h1d;
  localparam logic [4:0] BIT_ZINH_SYNDL = 5'h1c;
  localparam logic [4:0] BIT_LD_SYNB    = 5'h1b;
  localparam logic [4:0] BIT_RHR_SYNA   = 5'h1a;
  localparam logic [4:0] BIT_LD_TXBC    = 5'h19;
  localparam logic [4:0] BIT_LD_TXCRC   = 5'h18;
  localparam logic [4:0] BIT_XPARENT    = 5'h17;
  localparam logic [4:0] BIT_LD_CTRL    = 5'h0e;
  localparam logic [4:0] BIT_LD_INTV    = 5'h0d;
  localparam logic [4:0] BIT_LD_RXCRC   = 5'h0c;
  localparam int         DATA_BITS      = 12;

  // Load-enable flag bits within the flag vector (bits 12..14 of the space)
  localparam logic [31:0] FLAGS_RESET   = 32'h0000_4000;

  // Register offsets on AHB (byte addresses)
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_FLAGS  = 8'h04;
  localparam logic [7:0] OFS_MODE   = 8'h08;
  localparam logic [7:0] OFS_PULSES = 8'h0c;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_0 = 3'b000, MODE_1 = 3'b001, MODE_2 = 3'b010, MODE_3 = 3'b011,
    MODE_4 = 3'b100, MODE_5 = 3'b101, MODE_6 = 3'b110, MODE_7 = 3'b111
  } op_mode_e;

  // One command-bus write
  typedef struct packed {
    logic [4:0] sel;
    logic       data;
  } cmd_write_s;

  // One-cycle command strobes produced by a write
  typedef struct packed {
    logic dev_reset;
    logic transmitter_clear;
    logic receiver_clear;
    logic tx_crc_clear;
    logic rx_crc_clear;
    logic hold_flags_clear;
    logic tx_empty_clear;
  } cmd_pulse_s;

endpackage : cmd_decode_pkg

// ---- sim/host_cmd_bus_model.sv ----
`timescale 1ns/1ps
module host_cmd_bus_model (
  input  wire logic hclk,
  output logic [4:0] bit_select_lines,
  output logic       chip_select_n,
  output logic       cmd_bus_write_data,
  output logic       cmd_bus_write_strobe
);
  // Idle: deselected, strobe low
  initial begin
    bit_select_lines     = 5'h00;
    chip_select_n        = 1'b1;
    cmd_bus_write_data   = 1'b0;
    cmd_bus_write_strobe = 1'b0;
  end

  // One bit write; lines held 3 clocks either side so the sync stage sees them
  task automatic write_bit(input logic [4:0] addr, input logic val, input logic sel_on);
    @(posedge hclk);
    bit_select_lines   <= addr;
    chip_select_n      <= ~sel_on;
    cmd_bus_write_data <= val;
    repeat (3) @(posedge hclk);
    cmd_bus_write_strobe <= 1'b1;
    repeat (3) @(posedge hclk);
    cmd_bus_write_strobe <= 1'b0;
    repeat (3) @(posedge hclk);
    // Released lines show the inverse, never a stale value
    chip_select_n      <= 1'b1;
    cmd_bus_write_data <= ~val;
    bit_select_lines   <= ~addr;
  endtask : write_bit

  // Select without any strobe, for reading
  task automatic select(input logic on);
    @(posedge hclk);
    chip_select_n <= ~on;
  endtask : select
endmodule : host_cmd_bus_model

// ---- sim/serial_ctrl_command_bit_decoder_tb.sv ----
`timescale 1ns/1ps
module serial_ctrl_command_bit_decoder_tb;
  import cmd_decode_pkg::*;
  logic        hclk, hresetn, rd_bit_in, hsel, hwrite, cs_n_w, wd_w, stb_w;
  logic        rd_data, rd_oe, hreadyout, hresp, exp_empty;
  logic        stuff, discard, syncb, synca, hold_rd, txbc, tx_empty;
  logic [2:0]  op_mode, hsize;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, flag_bits, exp_bits, rd;
  logic [4:0]  sel_w;
  logic [11:0] data_field;
  logic [6:0]  pulse_seen;
  cmd_pulse_s  cmd_pulse;
  int          miscompares = 0;
  int          tests_run = 0;
  logic [4:0]  pa [5] = '{BIT_CLR_TXRX, BIT_CLR_TXRX, BIT_CLR_CRC, BIT_CLR_CRC, BIT_LD_TXBC};
  logic        pv [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [6:0]  pe [5] = '{7'h20, 7'h10, 7'h08, 7'h04, 7'h01};
  logic [2:0]  modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};

  host_cmd_bus_model host (.hclk(hclk), .bit_select_lines(sel_w), .chip_select_n(cs_n_w),
    .cmd_bus_write_data(wd_w), .cmd_bus_write_strobe(stb_w));

  serial_ctrl_command_bit_decoder i_dut (.hclk(hclk), .hresetn(hresetn),
    .bit_select_lines(sel_w), .chip_select_n(cs_n_w), .cmd_bus_write_data(wd_w),
    .cmd_bus_write_strobe(stb_w), .rd_bit_in(rd_bit_in), .cmd_bus_read_data(rd_data),
    .cmd_bus_read_oe(rd_oe), .op_mode(op_mode), .cmd_pulse(cmd_pulse),
    .data_field(data_field), .flag_bits(flag_bits), .tx_bit_stuff_inhibit(stuff),
    .rx_sync_char_discard(discard), .sync_b_load_enable(syncb), .sync_a_load_enable(synca),
    .hold_reg_read_enable(hold_rd), .txbuf_and_crc_load_enable(txbc),
    .tx_buffer_empty_flag(tx_empty), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));

  // Clock, 4 ns period
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Pulses last one cycle, so gather them between writes
  always @(posedge hclk) begin
    pulse_seen <= pulse_seen | cmd_pulse;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic check1(input string what, input logic seen, input logic exp);
    check(what, {31'h0, seen}, {31'h0, exp});
  endtask : check1

  task automatic settle();
    repeat (8) @(posedge hclk);
    #1;
  endtask : settle

  // Single AHB transfer; waits on hready in both phases
  task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    #1;
  endtask : ahb

  // Pin write, then stored bits, data field and tx-empty against the model
  task automatic pin_write(input logic [4:0] a, input logic v);
    pulse_seen = '0;
    host.write_bit(a, v, 1'b1);
    if (a == BIT_RESET) begin
      exp_bits  = FLAGS_RESET;
      exp_empty = 1'b1;
    end else begin
      exp_bits[a] = v;
      if (a == BIT_CLR_TXRX && v) exp_empty = 1'b1;
      if (a == BIT_LD_TXBC && !v) exp_empty = 1'b0;
    end
    settle();
    check("stored bits", flag_bits, exp_bits);
    check("data field", {20'h0, data_field}, {20'h0, exp_bits[11:0]});
    check1("tx empty", tx_empty, exp_empty);
  endtask : pin_write

  task automatic set_mode(input logic [2:0] m);
    @(posedge hclk);
    op_mode <= m;
    settle();
  endtask : set_mode

  task automatic stop_test();
    $display("Checks run %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // Hang guard, well past the expected run
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end

  initial begin
    hresetn = 1'b0;
    rd_bit_in = 1'b0;
    op_mode = 3'h0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    exp_bits = FLAGS_RESET;
    exp_empty = 1'b1;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    check("reset bits", flag_bits, FLAGS_RESET);
    check1("reset tx empty", tx_empty, 1'b1);
    // Every bit of the low space stores, ones then even zeros
    for (int i = 0; i < 26; i++) pin_write(5'(i), 1'b1);
    for (int i = 0; i < 26; i += 2) pin_write(5'(i), 1'b0);
    // Deselected strobe must not store; read line follows select
    host.write_bit(5'h03, 1'b0, 1'b0);
    settle();
    check("deselected write", flag_bits, exp_bits);
    @(posedge hclk);
    rd_bit_in <= 1'b1;
    host.select(1'b1);
    settle();
    check("read selected", {30'h0, rd_oe, rd_data}, 32'h3);
    host.select(1'b0);
    settle();
    check("read released", {30'h0, rd_oe, rd_data}, 32'h0);
    // Command pulses, exact set per write
    for (int k = 0; k < 5; k++) begin
      pin_write(pa[k], pv[k]);
      check("pulses", {25'h0, pulse_seen}, {25'h0, pe[k]});
    end
    pin_write(BIT_XPARENT, 1'b0);
    // Mode-dependent bits over modes 0-3 and unused modes 5 and 6
    for (int k = 0; k < 6; k++) begin
      set_mode(modes[k]);
      pin_write(BIT_ZINH_SYNDL, 1'b1);
      pin_write(BIT_LD_SYNB, 1'b1);
      pin_write(BIT_RHR_SYNA, 1'b1);
      check1("stuff inhibit", stuff, modes[k] == 3'h1);
      check1("sync discard", discard, modes[k] == 3'h3);
      check1("sync b load", syncb, modes[k] <= 3'h3);
      check1("hold read", hold_rd, modes[k] == 3'h1);
      check1("sync a load", synca, modes[k] inside {3'h2, 3'h3});
      pin_write(BIT_ZINH_SYNDL, 1'b0);
      pin_write(BIT_LD_SYNB, 1'b0);
      pin_write(BIT_RHR_SYNA, 1'b0);
      check1("hold clear", pulse_seen[1], modes[k] == 3'h1);
      check("levels off", {27'h0, stuff, discard, syncb, hold_rd, synca}, 32'h0);
    end
    // Discard gated off by the transparent bit; discard only exists in mode 3
    set_mode(3'h3);
    pin_write(BIT_ZINH_SYNDL, 1'b1);
    ahb(OFS_FLAGS, 1'b0, 32'h0);
    check("gated discard", {30'h0, rd[7], rd[1]}, 32'h3);
    pin_write(BIT_XPARENT, 1'b1);
    ahb(OFS_FLAGS, 1'b0, 32'h0);
    check("gated discard", {30'h0, rd[7], rd[1]}, 32'h1);
    pin_write(BIT_ZINH_SYNDL, 1'b0);
    // Software mode and command register
    ahb(OFS_MODE, 1'b1, 32'h0000_0101);
    ahb(OFS_MODE, 1'b0, 32'h0);
    check("mode reg", rd, 32'h0000_0101);
    pin_write(BIT_ZINH_SYNDL, 1'b1);
    check1("sw mode stuff", stuff, 1'b1);
    ahb(OFS_CMD, 1'b1, 32'h0000_0401);
    exp_bits[4] = 1'b1;
    settle();
    ahb(OFS_CMD, 1'b0, 32'h0);
    check("cmd reg", rd, exp_bits);
    ahb(8'h10, 1'b0, 32'h0);
    check("unmapped", rd, 32'h0);
    // Device reset by a zero write to bit 31
    pin_write(BIT_LD_TXBC, 1'b1);
    pin_write(BIT_RESET, 1'b0);
    check1("reset pulse", pulse_seen[6], 1'b1);
    check("levels reset", {29'h0, stuff, txbc, hold_rd}, 32'h0);
    stop_test();
  end
endmodule : serial_ctrl_command_bit_decoder_tb
